/* rtl/hvm_defines.svh */
// Constants for the host-to-VME master engine
`ifndef HVM_DEFINES_SVH
`define HVM_DEFINES_SVH
`define HVM_AM_SHORT_SUP 6'h2d
`define HVM_AM_STD_SUP_PROG 6'h3e
`define HVM_AM_EXT_SUP_PROG 6'h0e
`define HVM_DLEN_8 2'h1
`define HVM_DLEN_16 2'h2
`define HVM_DLEN_32 2'h3
`define HVM_DLEN_LO 16
`define HVM_DLEN_HI 17
`define HVM_SPACE_LO 18
`define HVM_SPACE_HI 19
`define HVM_OFFSET_RESET 32'h0003_0000
`define HVM_BUS_TIMEOUT_US 64
`define HVM_CLK_MHZ 25
`define HVM_BUS_TIMEOUT_CYC (`HVM_BUS_TIMEOUT_US * `HVM_CLK_MHZ)
`endif

/* rtl/hvm_pkg.sv */
// Types for the host-to-VME master engine
`default_nettype none
package hvm_pkg;
   typedef enum logic [2:0] {
      HVM_CMD_READ = 3'h0,
      HVM_CMD_WRITE = 3'h1,
      HVM_CMD_LOCK_READ = 3'h2,
      HVM_CMD_UNLOCK_WRITE = 3'h3,
      HVM_CMD_OTHER = 3'h4
   } hvm_cmd_e;
   typedef enum logic [1:0] {
      HVM_LEN_LONG = 2'h0,
      HVM_LEN_QUAD = 2'h1,
      HVM_LEN_OCTA = 2'h2,
      HVM_LEN_HEXA = 2'h3
   } hvm_len_e;
   typedef enum logic [1:0] {
      HVM_SPACE_SHORT = 2'h0,
      HVM_SPACE_STD = 2'h1,
      HVM_SPACE_EXT = 2'h2
   } hvm_space_e;
endpackage : hvm_pkg
`default_nettype wire

/* rtl/hvm_read_lane_sel.sv */
// Read byte-lane selection by slave data width and low address bits
`include "hvm_defines.svh"
`default_nettype none
module hvm_read_lane_sel
   import hvm_pkg::*;
(
   input wire logic [1:0] dlen,
   input wire logic [1:0] addr_lo,
   input wire logic [31:0] raw_data,
   output logic [31:0] sel_data,
   output logic [3:0] valid_lanes
);
   always_comb begin
      valid_lanes = 4'h0;
      case (dlen)
         `HVM_DLEN_8: valid_lanes = 4'h1 << addr_lo;
         `HVM_DLEN_16: begin
            if (addr_lo == 2'h0) begin
               valid_lanes = 4'h3;
            end else if (addr_lo == 2'h2) begin
               valid_lanes = 4'hc;
            end
         end
         `HVM_DLEN_32: begin
            if (addr_lo == 2'h0) begin
               valid_lanes = 4'hf;
            end
         end
         default: valid_lanes = 4'h0;
      endcase
   end

   // Full longword always returned; invalid lanes forced to zero
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign sel_data[g*8 +: 8] = valid_lanes[g] ? raw_data[g*8 +: 8] : 8'h00;
      end
   endgenerate
endmodule : hvm_read_lane_sel
`default_nettype wire

/* rtl/hvm_master_engine.sv */
// Host-to-VME master engine: arbitration, cycles, read return, locked pairs
`include "hvm_defines.svh"
`default_nettype none
module hvm_master_engine
   import hvm_pkg::*;
#(
   parameter int unsigned BUS_TIMEOUT_CYC = `HVM_BUS_TIMEOUT_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_b,
   // Host transaction buffer on the internal link bus
   input wire logic link_req_valid,
   output logic link_req_ready,
   input wire logic [2:0] link_req_cmd,
   input wire logic [1:0] link_req_len,
   input wire logic [31:0] link_req_addr,
   input wire logic [31:0] link_req_wdata,
   input wire logic [3:0] link_req_mask,
   output logic link_done,
   output logic link_err,
   output logic [31:0] link_rdata,
   output logic [3:0] link_rvalid_lanes,
   // Software field of host_xfer_offset_register
   input wire logic offset_wr,
   input wire logic [31:0] offset_wdata,
   output logic [31:0] host_xfer_offset_register,
   input wire logic irq_enable,
   input wire logic split_err_clear,
   output logic split_err,
   output logic split_irq,
   output logic illegal_err,
   // VMEbus master side
   output logic vme_bus_req,
   input wire logic vme_bus_grant,
   output logic vme_busy,
   output logic vme_as,
   output logic vme_ds_wr,
   output logic vme_ds_rd,
   output logic vme_rmw,
   output logic [31:0] vme_addr,
   output logic [5:0] vme_am,
   output logic [31:0] vme_wdata,
   output logic [3:0] vme_lanes,
   input wire logic vme_dtack,
   input wire logic vme_berr,
   input wire logic [31:0] vme_rdata
);
   typedef enum logic [2:0] {
      HVM_ST_IDLE = 3'h0,
      HVM_ST_ARB = 3'h1,
      HVM_ST_CYC = 3'h2,
      HVM_ST_END = 3'h3,
      HVM_ST_LOCKED = 3'h4,
      HVM_ST_DONE = 3'h5
   } hvm_state_e;

   localparam logic [31:0] TMO_LAST = 32'(BUS_TIMEOUT_CYC - 1);

   hvm_state_e state_r;
   logic [2:0] cmd_r;
   logic [31:0] addr_r;
   logic [31:0] wdata_r;
   logic [3:0] mask_r;
   logic [31:0] tmo_r;
   logic locked_r;
   logic accept;
   logic legal;
   logic is_write;
   logic cyc_end;
   logic timed_out;
   logic split_evt;
   logic timed_out_r;
   logic lock_hold;
   logic [31:0] sel_data;
   logic [3:0] sel_lanes;

   assign legal = (link_req_len == HVM_LEN_LONG) && (link_req_cmd != HVM_CMD_OTHER);
   assign link_req_ready = (state_r == HVM_ST_IDLE) || (state_r == HVM_ST_LOCKED);
   assign accept = link_req_valid && link_req_ready;
   assign is_write = (cmd_r == HVM_CMD_WRITE) || (cmd_r == HVM_CMD_UNLOCK_WRITE);
   assign timed_out = (tmo_r == TMO_LAST) || vme_berr;
   assign cyc_end = (state_r == HVM_ST_CYC) && (vme_dtack || timed_out);
   // Anything but a legal unlock write after a locking read splits the pair
   assign split_evt = (state_r == HVM_ST_LOCKED) && accept
                      && !(legal && link_req_cmd == HVM_CMD_UNLOCK_WRITE);
   // Locking read that ended with an acknowledge keeps the bus
   assign lock_hold = (cmd_r == HVM_CMD_LOCK_READ) && !timed_out_r;

   // Offset register with width and space fields, written by software
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         host_xfer_offset_register <= `HVM_OFFSET_RESET;
      end else if (offset_wr) begin
         host_xfer_offset_register <= offset_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state_r <= HVM_ST_IDLE;
      end else begin
         case (state_r)
            HVM_ST_IDLE: begin
               if (accept) begin
                  state_r <= legal ? HVM_ST_ARB : HVM_ST_DONE;
               end
            end
            HVM_ST_ARB: begin
               if (vme_bus_grant || locked_r) begin
                  state_r <= HVM_ST_CYC;
               end
            end
            HVM_ST_CYC: begin
               if (cyc_end) begin
                  state_r <= HVM_ST_END;
               end
            end
            HVM_ST_END: begin
               // Locking read holds the bus for the unlock write
               if (cmd_r == HVM_CMD_LOCK_READ && !timed_out_r) begin
                  state_r <= HVM_ST_LOCKED;
               end else begin
                  state_r <= HVM_ST_DONE;
               end
            end
            HVM_ST_LOCKED: begin
               if (accept) begin
                  state_r <= legal ? HVM_ST_ARB : HVM_ST_DONE;
               end
            end
            HVM_ST_DONE: state_r <= HVM_ST_IDLE;
            default: state_r <= HVM_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         timed_out_r <= 1'b0;
      end else if (accept) begin
         timed_out_r <= 1'b0;
      end else if (cyc_end) begin
         timed_out_r <= !vme_dtack;
      end
   end

   // Request capture from the host transaction buffer
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cmd_r <= 3'h0;
         addr_r <= 32'h0;
         wdata_r <= 32'h0;
         mask_r <= 4'h0;
      end else if (accept) begin
         cmd_r <= link_req_cmd;
         addr_r <= link_req_addr;
         wdata_r <= link_req_wdata;
         mask_r <= link_req_mask;
      end
   end

   // Lock holds ownership only while the pair stays intact
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         locked_r <= 1'b0;
      end else if (state_r == HVM_ST_END) begin
         locked_r <= (cmd_r == HVM_CMD_LOCK_READ) && !timed_out_r;
      end else if (split_evt) begin
         locked_r <= 1'b0;
      end else if (state_r == HVM_ST_DONE) begin
         locked_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tmo_r <= 32'h0;
      end else if (state_r == HVM_ST_CYC && !vme_dtack) begin
         tmo_r <= tmo_r + 32'h1;
      end else begin
         tmo_r <= 32'h0;
      end
   end

   // Bus ownership: held from grant through end, and across a lock
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         vme_bus_req <= 1'b0;
         vme_busy <= 1'b0;
      end else begin
         vme_bus_req <= (state_r == HVM_ST_ARB) && !vme_bus_grant && !locked_r;
         if (state_r == HVM_ST_ARB && (vme_bus_grant || locked_r)) begin
            vme_busy <= 1'b1;
         end else if (state_r == HVM_ST_END && !(cmd_r == HVM_CMD_LOCK_READ && !timed_out_r)) begin
            vme_busy <= 1'b0;
         end else if (split_evt) begin
            vme_busy <= 1'b0;
         end
      end
   end

   // Cycle drive: address, modifier and data presented together
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         vme_as <= 1'b0;
         vme_ds_wr <= 1'b0;
         vme_ds_rd <= 1'b0;
         vme_addr <= 32'h0;
         vme_am <= 6'h00;
         vme_wdata <= 32'h0;
         vme_lanes <= 4'h0;
      end else if (state_r == HVM_ST_ARB && (vme_bus_grant || locked_r)) begin
         vme_as <= 1'b1;
         vme_ds_wr <= is_write;
         vme_ds_rd <= !is_write;
         vme_addr <= addr_r;
         case (hvm_space_e'(host_xfer_offset_register[`HVM_SPACE_HI:`HVM_SPACE_LO]))
            HVM_SPACE_SHORT: vme_am <= `HVM_AM_SHORT_SUP;
            HVM_SPACE_STD: vme_am <= `HVM_AM_STD_SUP_PROG;
            HVM_SPACE_EXT: vme_am <= `HVM_AM_EXT_SUP_PROG;
            default: vme_am <= `HVM_AM_STD_SUP_PROG;
         endcase
         vme_wdata <= wdata_r;
         // Writes pass the mask straight through as lane enables; reads use sel_lanes
         vme_lanes <= is_write ? mask_r : sel_lanes;
      end else if (cyc_end) begin
         vme_as <= 1'b0;
         vme_ds_wr <= 1'b0;
         vme_ds_rd <= 1'b0;
      end
   end

   // Read-modify-write marker stays up from locking read to the end of its pair
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         vme_rmw <= 1'b0;
      end else if (state_r == HVM_ST_ARB && vme_bus_grant && cmd_r == HVM_CMD_LOCK_READ) begin
         vme_rmw <= 1'b1;
      end else if (split_evt || state_r == HVM_ST_DONE || state_r == HVM_ST_IDLE) begin
         vme_rmw <= 1'b0;
      end
   end

   hvm_read_lane_sel u_lane_sel (
      .dlen(host_xfer_offset_register[`HVM_DLEN_HI:`HVM_DLEN_LO]),
      .addr_lo(addr_r[1:0]),
      .raw_data(vme_rdata),
      .sel_data(sel_data),
      .valid_lanes(sel_lanes)
   );

   // Read data captured on acknowledge, returned on done
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         link_rdata <= 32'h0;
         link_rvalid_lanes <= 4'h0;
      end else if (cyc_end && !is_write) begin
         link_rdata <= vme_dtack ? sel_data : 32'h0;
         link_rvalid_lanes <= vme_dtack ? sel_lanes : 4'h0;
      end
   end

   // Completion toward host transmit logic
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         link_done <= 1'b0;
         link_err <= 1'b0;
      end else begin
         // Pulse from DONE, from END when the lock holds, and on a split; a splitting request pulses twice
         link_done <= (state_r == HVM_ST_DONE)
                      || (state_r == HVM_ST_END && lock_hold)
                      || split_evt;
         // Error rides on the same pulse as done
         link_err <= (state_r == HVM_ST_DONE) && (timed_out_r || illegal_err);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         illegal_err <= 1'b0;
      end else begin
         illegal_err <= accept && !legal;
      end
   end

   // Split-pair error: set wins over clear
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         split_err <= 1'b0;
      end else if (split_evt) begin
         split_err <= 1'b1;
      end else if (split_err_clear) begin
         split_err <= 1'b0;
      end
   end

   assign split_irq = split_err && irq_enable;
endmodule : hvm_master_engine
`default_nettype wire

/* bench/hvm_master_engine_props.sv */
// Port-level assertion checker for the host-to-VME master engine
`default_nettype none
module hvm_master_engine_props (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic link_req_valid,
   input wire logic link_req_ready,
   input wire logic [2:0] link_req_cmd,
   input wire logic [1:0] link_req_len,
   input wire logic link_done,
   input wire logic link_err,
   input wire logic [31:0] host_xfer_offset_register,
   input wire logic vme_bus_req,
   input wire logic vme_bus_grant,
   input wire logic vme_busy,
   input wire logic vme_as,
   input wire logic vme_ds_wr,
   input wire logic vme_ds_rd,
   input wire logic vme_rmw,
   input wire logic [5:0] vme_am,
   input wire logic vme_dtack
);
   default clocking dcb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   logic [1:0] sp;
   assign sp = host_xfer_offset_register[19:18];
   a_am_code: assert property ($rose(vme_as) |->
      vme_am == (sp == 2'h0 ? 6'h2d : sp == 2'h1 ? 6'h3e : 6'h0e)) else $error("bad modifier");
   a_own_grant: assert property ($rose(vme_busy) |-> $past(vme_bus_grant))
      else $error("bus taken without grant");
   a_ack_end: assert property (vme_as && vme_dtack |=> !vme_as)
      else $error("cycle not ended");
   a_done_after: assert property ($fell(vme_as) |-> ##[1:3] link_done)
      else $error("no done");
   a_read_rel: assert property ($fell(vme_as) && !vme_rmw |-> ##[0:3] !vme_busy)
      else $error("bus kept");
   a_lock_hold: assert property ($fell(vme_ds_rd) && vme_rmw |=> vme_busy [*2])
      else $error("lock released");
   a_rmw_write: assert property ($rose(vme_ds_wr) && vme_rmw |->
      $past(vme_busy) && !vme_bus_req) else $error("rmw write rearbitrated");
   a_illegal_req: assert property (link_req_valid && link_req_ready && !vme_busy &&
      (link_req_len != 2'h0 || link_req_cmd > 3'h3) |->
      (##2 (link_done && link_err)) and (!vme_bus_req [*3])) else $error("bad request run");
endmodule : hvm_master_engine_props
bind hvm_master_engine hvm_master_engine_props u_props (.*);
`default_nettype wire

/* bench/hvm_vme_slave.sv */
// Behavioural VMEbus slave with grant, answer lag and mute control
`default_nettype none
module hvm_vme_slave (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic vme_bus_req,
   output logic vme_bus_grant,
   input wire logic vme_as,
   input wire logic vme_ds_wr,
   input wire logic vme_ds_rd,
   input wire logic [31:0] vme_addr,
   input wire logic [31:0] vme_wdata,
   input wire logic [3:0] vme_lanes,
   input wire logic [2:0] lag,
   input wire logic mute,
   output logic vme_dtack,
   output logic [31:0] vme_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [16];
   logic [2:0] cnt_r;
   always @(posedge ref_clk) begin
      vme_bus_grant <= vme_bus_req && rst_b;
      if (!rst_b) begin
         cnt_r <= 3'h0;
         vme_dtack <= 1'b0;
         vme_rdata <= 32'h0;
      end else if (!vme_as) begin
         cnt_r <= 3'h0;
         vme_dtack <= 1'b0;
         // Released data lines toggle
         vme_rdata <= ~vme_rdata;
      end else if (!vme_dtack && !mute) begin
         cnt_r <= cnt_r + 3'h1;
         if (vme_ds_rd) vme_rdata <= mem[vme_addr[5:2]];
         if (cnt_r == lag) begin
            vme_dtack <= 1'b1;
            for (int b = 0; b < 4; b++) begin
               if (vme_ds_wr && vme_lanes[b]) begin
                  mem[vme_addr[5:2]][8*b +: 8] <= vme_wdata[8*b +: 8];
               end
            end
         end
      end
   end
endmodule : hvm_vme_slave
`default_nettype wire

/* bench/hvm_master_engine_tb_top.sv */
// Self-checking testbench for the host-to-VME master engine
`default_nettype none
module hvm_master_engine_tb_top
   import hvm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0, rst_b = 1'b0, link_req_valid = 1'b0, offset_wr = 1'b0;
   logic irq_enable = 1'b0, split_err_clear = 1'b0, mute = 1'b0, vme_berr = 1'b0;
   logic [2:0] link_req_cmd = 3'h0, lag = 3'h1;
   logic [1:0] link_req_len = 2'h0;
   logic [31:0] link_req_addr = 32'h0, link_req_wdata = 32'h0, offset_wdata = 32'h0;
   logic [3:0] link_req_mask = 4'h0, link_rvalid_lanes, vme_lanes, last_lanes;
   logic link_req_ready, link_done, link_err, split_err, split_irq, illegal_err, er;
   logic vme_bus_req, vme_bus_grant, vme_busy, vme_as, vme_ds_wr, vme_ds_rd, vme_rmw;
   logic vme_dtack, rmw_wr, req_seen;
   logic [31:0] link_rdata, host_xfer_offset_register, vme_addr, vme_wdata, vme_rdata, rd;
   logic [5:0] vme_am, last_am;
   int err_total = 0, samples_checked = 0;
   hvm_master_engine #(.BUS_TIMEOUT_CYC(20)) uut (.*);
   hvm_vme_slave slv (.*);
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (vme_as === 1'b1 && vme_dtack === 1'b1) begin
         last_am <= vme_am;
         last_lanes <= vme_lanes;
      end
      if (vme_bus_req === 1'b1) req_seen <= 1'b1;
      if (vme_ds_wr === 1'b1 && vme_rmw === 1'b1) rmw_wr <= 1'b1;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic summarize();
      $display("compares=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   function automatic logic [31:0] bm(input logic [3:0] l);
      return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
   endfunction : bm
   function automatic logic [3:0] exp_lanes(input logic [1:0] w, input logic [1:0] a);
      if (w == 2'h1) return 4'h1 << a;
      if (w == 2'h2) return a == 2'h0 ? 4'h3 : a == 2'h2 ? 4'hc : 4'h0;
      return a == 2'h0 ? 4'hf : 4'h0;
   endfunction : exp_lanes
   task automatic set_off(input logic [1:0] w, input logic [1:0] sp);
      offset_wdata <= {12'h0, sp, w, 16'h0};
      offset_wr <= 1'b1;
      @(posedge ref_clk);
      offset_wr <= 1'b0;
      @(posedge ref_clk);
      chk(host_xfer_offset_register, {12'h0, sp, w, 16'h0});
   endtask : set_off
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (link_done !== 1'b1 && n < 99);
      chk({31'h0, link_done}, 32'h1);
      rd = link_rdata;
      er = link_err;
      @(posedge ref_clk);
   endtask : wait_done
   task automatic xfer(input logic [2:0] c, input logic [1:0] l, input logic [31:0] a,
      input logic [31:0] d, input logic [3:0] m);
      link_req_cmd <= c;
      link_req_len <= l;
      link_req_addr <= a;
      link_req_wdata <= d;
      link_req_mask <= m;
      link_req_valid <= 1'b1;
      do @(negedge ref_clk); while (link_req_ready !== 1'b1);
      @(posedge ref_clk);
      link_req_valid <= 1'b0;
      wait_done();
   endtask : xfer
   task automatic t_masks();
      logic [3:0] mt [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h7, 4'he, 4'hf};
      logic [5:0] amt [3] = '{6'h2d, 6'h3e, 6'h0e};
      for (int i = 0; i < 9; i++) begin
         set_off(2'h3, 2'(i % 3));
         lag <= 3'(1 + i % 4);
         xfer(HVM_CMD_WRITE, 2'h0, 32'h20, 32'h0, 4'hf);
         xfer(HVM_CMD_WRITE, 2'h0, 32'h20, 32'h5a6b7c8d, mt[i]);
         chk({28'h0, last_lanes}, {28'h0, mt[i]});
         chk({26'h0, last_am}, {26'h0, amt[i % 3]});
         xfer(HVM_CMD_READ, 2'h0, 32'h20, 32'h0, 4'hf);
         chk(rd, 32'h5a6b7c8d & bm(mt[i]));
      end
   endtask : t_masks
   task automatic t_lanes();
      logic [3:0] l;
      xfer(HVM_CMD_WRITE, 2'h0, 32'h10, 32'ha1b2c3d4, 4'hf);
      for (int w = 1; w < 4; w++) begin
         set_off(2'(w), 2'h1);
         for (int a = 0; a < 4; a++) begin
            l = exp_lanes(2'(w), 2'(a));
            xfer(HVM_CMD_READ, 2'h0, 32'h10 + 32'(a), 32'h0, 4'hf);
            chk({28'h0, link_rvalid_lanes}, {28'h0, l});
            chk(rd, 32'ha1b2c3d4 & bm(l));
         end
      end
   endtask : t_lanes
   task automatic t_lock();
      rmw_wr <= 1'b0;
      xfer(HVM_CMD_LOCK_READ, 2'h0, 32'h20, 32'h0, 4'hf);
      chk({31'h0, vme_busy}, 32'h1);
      xfer(HVM_CMD_UNLOCK_WRITE, 2'h0, 32'h20, 32'h13579bdf, 4'hf);
      chk({30'h0, rmw_wr, split_err}, 32'h2);
      xfer(HVM_CMD_READ, 2'h0, 32'h20, 32'h0, 4'hf);
      chk(rd, 32'h13579bdf);
   endtask : t_lock
   task automatic t_split();
      irq_enable <= 1'b1;
      xfer(HVM_CMD_LOCK_READ, 2'h0, 32'h20, 32'h0, 4'hf);
      rmw_wr <= 1'b0;
      xfer(HVM_CMD_WRITE, 2'h0, 32'h20, 32'h2468ace0, 4'hf);
      wait_done();
      chk({30'h0, split_err, split_irq}, 32'h3);
      xfer(HVM_CMD_UNLOCK_WRITE, 2'h0, 32'h24, 32'h11, 4'hf);
      xfer(HVM_CMD_READ, 2'h0, 32'h20, 32'h0, 4'hf);
      chk({rd[31:1], rmw_wr}, 32'h2468ace0);
      split_err_clear <= 1'b1;
      @(posedge ref_clk);
      split_err_clear <= 1'b0;
      @(posedge ref_clk);
      chk({30'h0, split_err, split_irq}, 32'h0);
   endtask : t_split
   task automatic t_faults();
      mute <= 1'b1;
      xfer(HVM_CMD_READ, 2'h0, 32'h20, 32'h0, 4'hf);
      chk({er, rd[30:0]}, 32'h80000000);
      mute <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         req_seen <= 1'b0;
         xfer(i == 0 ? HVM_CMD_OTHER : HVM_CMD_WRITE, 2'(i), 32'h20, 32'h0, 4'hf);
         chk({30'h0, er, req_seen}, 32'h2);
      end
   endtask : t_faults
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      chk(host_xfer_offset_register, 32'h0003_0000);
      t_masks();
      t_lanes();
      t_lock();
      t_split();
      t_faults();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      summarize();
   end
endmodule : hvm_master_engine_tb_top
`default_nettype wire
